/* acl_pkg.sv */
// Shared constants, types and field layouts of the amplifier control and status bank.
// Assumes a single 100 MHz core clock and byte-wide registers behind an I2C target.
package acl_pkg;

   // Register offsets (byte addresses on the I2C register pointer)
   localparam logic [7:0] ACL_OFS_ACDIAG_LOW = 8'h1E;
   localparam logic [7:0] ACL_OFS_MISC3 = 8'h21;
   localparam logic [7:0] ACL_OFS_CLIP_CTRL = 8'h22;
   localparam logic [7:0] ACL_OFS_CLIP_WIN = 8'h23;
   localparam logic [7:0] ACL_OFS_CLIP_FLAGS = 8'h24;
   localparam logic [7:0] ACL_OFS_ILIM_FLAGS = 8'h25;
   localparam logic [7:0] ACL_OFS_MISC4 = 8'h26;

   // Reset values
   localparam logic [7:0] ACL_RST_MISC3 = 8'h00;
   localparam logic [7:0] ACL_RST_CLIP_CTRL = 8'h01;
   localparam logic [7:0] ACL_RST_CLIP_WIN = 8'h14;
   localparam logic [7:0] ACL_RST_MISC4 = 8'h40;
   localparam logic [7:0] ACL_ZERO = 8'h00;

   // Field positions in the third miscellaneous control register
   localparam int ACL_B_CLEAR_FAULT = 7;
   localparam int ACL_B_PB_SRC = 6;
   localparam int ACL_B_ILIM_MASK = 5;
   localparam int ACL_B_MISC3_RSVD = 4;
   localparam int ACL_B_OT_AUTO = 3;
   // Clip detect enable in the clip control register
   localparam int ACL_B_CLIP_EN = 0;
   // High-pass corner field and the writable upper part of misc control 4
   localparam int ACL_HPF_MSB = 2;
   localparam int ACL_M4_UP_LSB = 3;

   // Switching frequency multiples of the sample rate
   localparam logic [5:0] ACL_FSW_8 = 6'h08;
   localparam logic [5:0] ACL_FSW_10 = 6'h0A;
   localparam logic [5:0] ACL_FSW_38 = 6'h26;
   localparam logic [5:0] ACL_FSW_44 = 6'h2C;
   localparam logic [5:0] ACL_FSW_48 = 6'h30;

   // Switching frequency selection codes
   typedef enum logic [2:0] {
      ACL_SW_8FS = 3'h0,
      ACL_SW_10FS = 3'h1,
      ACL_SW_38FS = 3'h2,
      ACL_SW_44FS = 3'h3,
      ACL_SW_48FS = 3'h4
   } acl_swsel_e;

   // Raw analog event indications, carried together through the synchroniser
   typedef struct packed {
      logic overtemp;
      logic [1:0] clip;
      logic [1:0] ilim;
   } acl_sense_s;

   // Register write strobe from the I2C target
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } acl_wr_s;

endpackage

/* acl_i2c_target.sv */
// I2C target: device address match, register pointer, auto-incrementing reads and writes.
// Assumes SCL and SDA arrive asynchronously and are far slower than the core clock.
`timescale 1ns/1ns
`default_nettype none
module acl_i2c_target #(
   parameter logic [6:0] DEV_ADDR = 7'h35 // Arbitrary target address
)(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   output acl_pkg::acl_wr_s o_wr,
   output logic [7:0] o_ptr,
   input wire logic [7:0] i_rdata
);
   typedef enum logic [2:0] {
      ACL_ST_IDLE = 3'h0,
      ACL_ST_ADDR = 3'h1,
      ACL_ST_PTR = 3'h2,
      ACL_ST_WR = 3'h3,
      ACL_ST_RD = 3'h4
   } acl_i2c_e;

   logic [1:0] scl_q, sda_q; // Two-stage synchronisers, stage 0 read only by stage 1
   logic scl_d, sda_d; // Previous synchronised values for edge detection
   acl_i2c_e st_r;
   logic [2:0] cnt_r;
   logic [7:0] sh_r, tx_r, ptr_r;
   logic full_r, ack_r, drv_ack_r;
   acl_pkg::acl_wr_s wr_r;

   wire scl_s = scl_q[1];
   wire sda_s = sda_q[1];
   wire start_c = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
   wire rise_c = scl_s & ~scl_d;
   wire fall_c = ~scl_s & scl_d;
   wire match_c = (sh_r[7:1] == DEV_ADDR);

   // Synchronise the bus pins before anything looks at them
   always_ff @(posedge i_clk)
   begin
      scl_q <= {scl_q[0], i_scl};
      sda_q <= {sda_q[0], i_sda};
      scl_d <= scl_s;
      sda_d <= sda_s;
   end

   // Byte engine; start and stop win over any bit activity
   always_ff @(posedge i_clk)
   begin
      wr_r.wr <= 1'b0;
      if (!i_rstn)
      begin
         st_r <= ACL_ST_IDLE;
         cnt_r <= 3'h0;
         sh_r <= 8'h00;
         tx_r <= 8'hFF;
         ptr_r <= 8'h00;
         full_r <= 1'b0;
         ack_r <= 1'b0;
         drv_ack_r <= 1'b0;
         wr_r <= '0;
      end
      else if (start_c || stop_c)
      begin
         st_r <= start_c ? ACL_ST_ADDR : ACL_ST_IDLE;
         cnt_r <= 3'h0;
         full_r <= 1'b0;
         ack_r <= 1'b0;
         drv_ack_r <= 1'b0;
         tx_r <= 8'hFF;
      end
      else if (rise_c && st_r != ACL_ST_IDLE)
      begin
         if (ack_r)
         begin
            // Controller NACK after a read byte ends the read
            if (st_r == ACL_ST_RD && sda_s)
               st_r <= ACL_ST_IDLE;
         end
         else
         begin
            sh_r <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 3'h1;
            full_r <= (cnt_r == 3'h7);
         end
      end
      else if (fall_c && st_r != ACL_ST_IDLE)
      begin
         if (full_r)
         begin
            // Eighth bit done: enter the acknowledge slot
            full_r <= 1'b0;
            ack_r <= 1'b1;
            drv_ack_r <= 1'b0;
            tx_r <= 8'hFF;
            unique case (st_r)
               ACL_ST_ADDR:
               begin
                  drv_ack_r <= match_c;
                  st_r <= !match_c ? ACL_ST_IDLE : (sh_r[0] ? ACL_ST_RD : ACL_ST_PTR);
               end
               ACL_ST_PTR:
               begin
                  drv_ack_r <= 1'b1;
                  ptr_r <= sh_r;
                  st_r <= ACL_ST_WR;
               end
               ACL_ST_WR:
               begin
                  drv_ack_r <= 1'b1;
                  wr_r <= '{wr: 1'b1, addr: ptr_r, data: sh_r};
                  ptr_r <= ptr_r + 8'h01;
               end
               ACL_ST_RD: ;
               ACL_ST_IDLE: ;
            endcase
         end
         else if (ack_r)
         begin
            // Leaving the acknowledge slot; a read loads the next byte
            ack_r <= 1'b0;
            drv_ack_r <= 1'b0;
            if (st_r == ACL_ST_RD)
            begin
               tx_r <= i_rdata;
               ptr_r <= ptr_r + 8'h01;
            end
         end
         else if (st_r == ACL_ST_RD)
            tx_r <= {tx_r[6:0], 1'b1};
      end
   end

   // Open-drain: only ever pull low
   assign o_sda_o = 1'b0; // RL17
   assign o_sda_oe = drv_ack_r | (st_r == ACL_ST_RD && !ack_r && !tx_r[7]);
   assign o_wr = wr_r;
   assign o_ptr = ptr_r;

endmodule // acl_i2c_target
`default_nettype wire

/* acl_regbank.sv */
// Control and status register bank of a two-channel class-D amplifier, reached over I2C.
// Assumes analog event inputs are asynchronous; mode inputs come from core-clock logic.
// Overview of operation
// (RL1) Writing one to fault-clear bit clears faults
// (RL2) Bit six picks normal or swapped bridge source
// (RL3) Bit five masks current-limit warnings off warn pin
// (RL4) Bit three chooses latched or self-recovering overtemperature
// (RL5) Clip detection enable bit, reset enabled
// (RL6) Eight-bit clip window register, resets 0x14
// (RL7) Per-channel read-only clip flags
// (RL8) Per-channel read-only current-limit flags
// (RL9) Three-bit high-pass corner field, register resets 0x40
// (RL10) Read-only diagnostic secondary report low byte
// (RL11) Switching frequency 38/44/48 or 8/10 fs
// (RL12) Bridged channels in unequal states raise fault
// (RL13) Bridge mode changes only in standby
// (RL14) Load diagnostics allowed in bridge mode
// (RL15) Host selects line-driver mode via register zero; this bank does not map register zero
// (RL16) Host configures, clears, checks faults, then plays
// (RL17) I2C target only, at most 400 kHz
// (RL18) Fault-clear bit self-clears after the clear
`timescale 1ns/1ns
`default_nettype none
module acl_regbank #(
   parameter logic [6:0] DEV_ADDR = 7'h35, // Arbitrary target address
   parameter int CH_STATE_W = 2 // Width of a channel state code
)(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_scl, // I2C clock pin
   input wire logic i_sda, // I2C data pin, input side
   output logic o_sda_o, // I2C data output level (always low)
   output logic o_sda_oe, // High while pulling SDA low
   input wire logic i_overtemp, // Async overtemperature shutdown condition
   input wire logic [1:0] i_clip_raw, // Async per-channel clip indications
   input wire logic [1:0] i_ilim_raw, // Async per-channel current-limit events
   input wire logic i_ac_diag_valid, // Diagnostic result strobe
   input wire logic [7:0] i_ac_diag_low, // Diagnostic secondary report low byte
   input wire logic i_standby, // Device is in standby
   input wire logic i_parallel_bridge_mode_req, // Requested bridge mode
   input wire logic [CH_STATE_W-1:0] i_ch1_state, // Channel one state
   input wire logic [CH_STATE_W-1:0] i_ch2_state, // Channel two state
   input wire logic [2:0] i_sw_freq_sel, // Switching frequency code
   input wire logic i_diag_req, // Load diagnostic request pulse
   output logic o_diag_start, // Load diagnostic start pulse
   output logic [5:0] o_sw_freq_mult, // Switching frequency as multiple of fs
   output logic o_parallel_bridge_mode, // Bridge mode in force
   output logic o_parallel_bridge_source_sel, // Swapped bridge source
   output logic [2:0] o_highpass_corner_sel, // High-pass corner code
   output logic [7:0] o_clip_window, // Window used by clip detection
   output logic o_fault_n, // Fault pin, low while any fault latched
   output logic o_warn_n, // Warn pin, low while a warning shows
   output logic o_otsd_latched, // Overtemperature shutdown in force
   output logic o_parallel_bridge_mode_fault // Bridged channel state mismatch
);
   // Switching frequency decode; illegal codes fall back to 44 fs
   function automatic logic [5:0] fsw_mult(input logic [2:0] sel);
      unique case (sel)
         acl_pkg::ACL_SW_8FS: fsw_mult = acl_pkg::ACL_FSW_8;
         acl_pkg::ACL_SW_10FS: fsw_mult = acl_pkg::ACL_FSW_10;
         acl_pkg::ACL_SW_38FS: fsw_mult = acl_pkg::ACL_FSW_38;
         acl_pkg::ACL_SW_48FS: fsw_mult = acl_pkg::ACL_FSW_48;
         default: fsw_mult = acl_pkg::ACL_FSW_44;
      endcase
   endfunction

   acl_pkg::acl_wr_s wr; // Write strobe from the I2C target
   logic [7:0] ptr; // Current register pointer
   logic [7:0] rdata; // Read data for the pointer
   acl_pkg::acl_sense_s sense_q0, sense_s; // Event synchroniser stages
   logic [7:0] misc3_r, clip_ctrl_r, clip_win_r, misc4_r, acd_r;
   logic clr_pend_r; // Fault-clear command pending
   logic otsd_r, parallel_bridge_mode_fault_r, parallel_bridge_mode_mode_r;
   logic [1:0] clip_flags_r, ilim_flags_r;
   logic [7:0] clip_cnt_r [2]; // Per-channel clip persistence counters
   logic [1:0] clip_hit; // Clip persisted for the window
   logic warn_r, diag_r;
   logic [5:0] fsw_r;

   acl_i2c_target #(
      .DEV_ADDR(DEV_ADDR)
   ) u_i2c (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_sda_o(o_sda_o),
      .o_sda_oe(o_sda_oe),
      .o_wr(wr),
      .o_ptr(ptr),
      .i_rdata(rdata)
   );

   // Address decode of the write strobe
   wire wr_m3 = wr.wr && wr.addr == acl_pkg::ACL_OFS_MISC3;
   wire wr_cc = wr.wr && wr.addr == acl_pkg::ACL_OFS_CLIP_CTRL;
   wire wr_cw = wr.wr && wr.addr == acl_pkg::ACL_OFS_CLIP_WIN;
   wire wr_m4 = wr.wr && wr.addr == acl_pkg::ACL_OFS_MISC4;
   wire wr_clr = wr_m3 && wr.data[acl_pkg::ACL_B_CLEAR_FAULT];
   wire ot_auto = misc3_r[acl_pkg::ACL_B_OT_AUTO];
   wire ilim_mask = misc3_r[acl_pkg::ACL_B_ILIM_MASK];
   wire clip_en = clip_ctrl_r[acl_pkg::ACL_B_CLIP_EN];
   wire ch_mismatch = parallel_bridge_mode_mode_r && (i_ch1_state != i_ch2_state);

   // Read view: fault-clear bit shows one only while the clear is pending
   wire [7:0] misc3_rd = {clr_pend_r, misc3_r[6:0]};
   wire [7:0] clip_rd = {6'h00, clip_flags_r};
   wire [7:0] ilim_rd = {6'h00, ilim_flags_r};
   assign rdata = (ptr == acl_pkg::ACL_OFS_MISC3) ? misc3_rd :
                  (ptr == acl_pkg::ACL_OFS_CLIP_CTRL) ? clip_ctrl_r :
                  (ptr == acl_pkg::ACL_OFS_CLIP_WIN) ? clip_win_r :
                  (ptr == acl_pkg::ACL_OFS_CLIP_FLAGS) ? clip_rd : // RL7
                  (ptr == acl_pkg::ACL_OFS_ILIM_FLAGS) ? ilim_rd : // RL8
                  (ptr == acl_pkg::ACL_OFS_MISC4) ? misc4_r :
                  (ptr == acl_pkg::ACL_OFS_ACDIAG_LOW) ? acd_r : // RL10
                  acl_pkg::ACL_ZERO; // Unmapped reads return zero

   // Analog events are asynchronous; two flops before any use
   always_ff @(posedge i_clk)
   begin
      sense_q0 <= '{overtemp: i_overtemp, clip: i_clip_raw, ilim: i_ilim_raw};
      sense_s <= sense_q0;
   end

   // Writable control registers; reserved low bits of misc3 stay zero
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         misc3_r <= acl_pkg::ACL_RST_MISC3;
         clip_ctrl_r <= acl_pkg::ACL_RST_CLIP_CTRL; // RL5
         clip_win_r <= acl_pkg::ACL_RST_CLIP_WIN; // RL6
         misc4_r <= acl_pkg::ACL_RST_MISC4; // RL9
      end
      else
      begin
         if (wr_m3)
            misc3_r <= {1'b0, wr.data[acl_pkg::ACL_B_PB_SRC:acl_pkg::ACL_B_OT_AUTO], 3'h0};
         if (wr_cc)
            clip_ctrl_r <= {7'h00, wr.data[acl_pkg::ACL_B_CLIP_EN]}; // RL5
         if (wr_cw)
            clip_win_r <= wr.data; // RL6
         if (wr_m4)
            misc4_r <= wr.data; // RL9
      end
   end

   // One-shot fault clear: pending for one cycle, then reads back zero
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         clr_pend_r <= 1'b0;
      else
         clr_pend_r <= wr_clr; // RL18
   end

   // Clip persistence: a clip counts once it has lasted the window length
   for (genvar c = 0; c < 2; c++)
   begin : g_clip
      assign clip_hit[c] = sense_s.clip[c] && (clip_cnt_r[c] >= clip_win_r); // RL6
      always_ff @(posedge i_clk)
      begin
         if (!i_rstn || !sense_s.clip[c] || !clip_en)
            clip_cnt_r[c] <= 8'h00;
         else if (clip_cnt_r[c] != 8'hFF)
            clip_cnt_r[c] <= clip_cnt_r[c] + 8'h01;
      end
   end

   // Sticky status; a new event in the clear cycle wins over the clear
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         clip_flags_r <= 2'h0;
         ilim_flags_r <= 2'h0;
         otsd_r <= 1'b0;
         parallel_bridge_mode_fault_r <= 1'b0;
         acd_r <= acl_pkg::ACL_ZERO;
      end
      else
      begin
         clip_flags_r <= (clr_pend_r ? 2'h0 : clip_flags_r) | (clip_en ? clip_hit : 2'h0); // RL7
         ilim_flags_r <= (clr_pend_r ? 2'h0 : ilim_flags_r) | sense_s.ilim; // RL8
         // Auto mode drops the shutdown once the condition is gone
         otsd_r <= sense_s.overtemp | (otsd_r & ~clr_pend_r & ~ot_auto); // RL4 RL1
         parallel_bridge_mode_fault_r <= ch_mismatch | (parallel_bridge_mode_fault_r & ~clr_pend_r); // RL12 RL1
         if (i_ac_diag_valid)
            acd_r <= i_ac_diag_low; // RL10
      end
   end

   // Bridge mode follows the request only in standby; diagnostics run in either mode
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         parallel_bridge_mode_mode_r <= 1'b0;
         diag_r <= 1'b0;
         fsw_r <= acl_pkg::ACL_FSW_44;
         warn_r <= 1'b0;
      end
      else
      begin
         if (i_standby)
            parallel_bridge_mode_mode_r <= i_parallel_bridge_mode_req; // RL13
         diag_r <= i_diag_req; // RL14
         fsw_r <= fsw_mult(i_sw_freq_sel); // RL11
         warn_r <= (|clip_flags_r) | ((|ilim_flags_r) & ~ilim_mask); // RL3
      end
   end

   assign o_diag_start = diag_r;
   assign o_sw_freq_mult = fsw_r;
   assign o_parallel_bridge_mode = parallel_bridge_mode_mode_r;
   assign o_parallel_bridge_source_sel = misc3_r[acl_pkg::ACL_B_PB_SRC]; // RL2
   assign o_highpass_corner_sel = misc4_r[acl_pkg::ACL_HPF_MSB:0]; // RL9
   assign o_clip_window = clip_win_r;
   assign o_fault_n = ~(otsd_r | parallel_bridge_mode_fault_r);
   assign o_warn_n = ~warn_r;
   assign o_otsd_latched = otsd_r;
   assign o_parallel_bridge_mode_fault = parallel_bridge_mode_fault_r;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   property p_clr_clears;
      clr_pend_r && !sense_s.overtemp && !ch_mismatch |=> !otsd_r && !parallel_bridge_mode_fault_r;
   endproperty
   a_clr_clears: assert property (p_clr_clears) else $error("fault clear failed"); // RL1

   property p_src_sel;
      wr_m3 |=> o_parallel_bridge_source_sel == $past(wr.data[acl_pkg::ACL_B_PB_SRC]);
   endproperty
   a_src_sel: assert property (p_src_sel) else $error("bridge source not updated"); // RL2

   property p_ilim_mask;
      ilim_mask && clip_flags_r == 2'h0 && !wr_m3 |=> o_warn_n;
   endproperty
   a_ilim_mask: assert property (p_ilim_mask) else $error("masked limit reached warn"); // RL3

   property p_ot_latch;
      otsd_r && !clr_pend_r && !ot_auto |=> otsd_r;
   endproperty
   a_ot_latch: assert property (p_ot_latch) else $error("shutdown not latched"); // RL4

   property p_ot_auto;
      otsd_r && ot_auto && !sense_s.overtemp |=> !otsd_r;
   endproperty
   a_ot_auto: assert property (p_ot_auto) else $error("auto recovery missed"); // RL4

   property p_clip_off;
      !clip_en && clip_flags_r == 2'h0 |=> clip_flags_r == 2'h0;
   endproperty
   a_clip_off: assert property (p_clip_off) else $error("clip flag while disabled"); // RL5

   // A clear in the cycle after the event may legally drop the flag again
   property p_ilim_set;
      sense_s.ilim[1] |=> ilim_flags_r[1] ##1 (ilim_flags_r[1] || $past(clr_pend_r));
   endproperty
   a_ilim_set: assert property (p_ilim_set) else $error("limit flag not sticky"); // RL8

   property p_acd;
      i_ac_diag_valid |=> acd_r == $past(i_ac_diag_low);
   endproperty
   a_acd: assert property (p_acd) else $error("diag low byte not captured"); // RL10

   property p_parallel_bridge_mode_fault;
      ch_mismatch |=> parallel_bridge_mode_fault_r && !o_fault_n;
   endproperty
   a_parallel_bridge_mode_fault: assert property (p_parallel_bridge_mode_fault) else $error("mismatch not reported"); // RL12

   property p_parallel_bridge_mode_standby;
      !i_standby |=> $stable(parallel_bridge_mode_mode_r);
   endproperty
   a_parallel_bridge_mode_standby: assert property (p_parallel_bridge_mode_standby) else $error("mode changed in play"); // RL13

   property p_clr_oneshot;
      wr_clr ##1 !wr_clr |=> !clr_pend_r;
   endproperty
   a_clr_oneshot: assert property (p_clr_oneshot) else $error("clear bit stuck"); // RL18

   c_clear: cover property (wr_clr ##1 clr_pend_r ##1 !clr_pend_r);
   c_parallel_bridge_mode_fault: cover property (parallel_bridge_mode_mode_r && ch_mismatch ##1 parallel_bridge_mode_fault_r);
   c_clip: cover property (clip_en && clip_hit != 2'h0 ##1 !o_warn_n);
   c_ot_auto: cover property (otsd_r && ot_auto ##1 !otsd_r);

endmodule // acl_regbank
`default_nettype wire

/* acl_i2c_host.sv */
// Behavioural I2C controller standing in for the system controller.
// Assumes SDA is open drain with a pull-up, resolved by the testbench.
`timescale 1ns/1ns
`default_nettype none
module acl_i2c_host #(
   parameter int Q = 63 // Quarter SCL period in core clocks, keeps SCL under 400 kHz
)(
   input wire logic i_clk,
   input wire logic i_sda, // Resolved SDA level
   output logic o_scl, // SCL, driven push-pull by the controller
   output logic o_sda_oe // High while pulling SDA low
);
   localparam logic [6:0] ADDR = 7'h35; // Arbitrary target address
   int nack_count = 0; // Acknowledges the target failed to give
   logic [7:0] rd_q [$]; // Bytes returned by the last read

   // Bus idle: both lines released high
   initial
   begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end

   // Wait a number of core clocks, changing lines just after a falling edge
   task automatic w(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // One SCL period; SDA only moves a quarter after SCL fell to keep hold time
   task automatic bit_x(input logic b, output logic s);
      w(Q);
      o_sda_oe = ~b;
      w(Q);
      o_scl = 1'b1;
      w(Q);
      s = i_sda; // Sampled mid-high, where the target's bit stands
      w(Q);
      o_scl = 1'b0;
   endtask

   // Start, or repeated start when SCL is low
   task automatic start();
      if (o_scl === 1'b0)
      begin
         w(Q);
         o_sda_oe = 1'b0;
         w(Q);
         o_scl = 1'b1;
      end
      w(Q);
      o_sda_oe = 1'b1;
      w(Q);
      o_scl = 1'b0;
   endtask

   // Stop: SDA rises while SCL is high
   task automatic stop();
      w(Q);
      o_sda_oe = 1'b1;
      w(Q);
      o_scl = 1'b1;
      w(Q);
      o_sda_oe = 1'b0;
      w(Q);
   endtask

   // Byte out, MSB first, then the target's acknowledge
   task automatic send(input logic [7:0] d);
      logic [7:0] r;
      logic a;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
      bit_x(1'b1, a);
      if (a !== 1'b0) nack_count++;
   endtask

   // Pointer, then data bytes to consecutive registers
   task automatic write_regs(input logic [7:0] ptr, input logic [7:0] d [$]);
      start();
      send({ADDR, 1'b0});
      send(ptr);
      foreach (d[k]) send(d[k]);
      stop();
   endtask

   // Pointer, repeated start, n bytes; the last one is not acknowledged
   task automatic read_regs(input logic [7:0] ptr, input int n);
      logic [7:0] r;
      logic a;
      start();
      send({ADDR, 1'b0});
      send(ptr);
      start();
      send({ADDR, 1'b1});
      rd_q.delete();
      for (int k = 0; k < n; k++)
      begin
         for (int i = 7; i >= 0; i--) bit_x(1'b1, r[i]);
         bit_x(k == n - 1, a);
         rd_q.push_back(r);
      end
      stop();
   endtask
endmodule // acl_i2c_host
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench of the amplifier control and status bank.
// Assumes the I2C controller model drives the register side; the bench drives the rest.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic scl, host_oe, dut_oe, dut_sda_o, ot, dv, stby, preq, dreq;
   logic [1:0] clip, ilim, s1, s2;
   logic [2:0] fsel, hpc;
   logic [7:0] dlow, cwin;
   logic dstart, pbm, src, fault_n, warn_n, otsd, pbf;
   logic [5:0] mult;
   wire sda;
   int fail_count = 0; // Mismatches seen
   int num_checks = 0; // Comparisons made

   // Open-drain SDA: low while any party pulls, else the pull-up wins
   assign sda = !(host_oe || (dut_oe && !dut_sda_o));

   acl_regbank #(.DEV_ADDR(7'h35), .CH_STATE_W(2)) i_acl_regbank (.i_clk(i_clk),
      .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda), .o_sda_o(dut_sda_o), .o_sda_oe(dut_oe),
      .i_overtemp(ot), .i_clip_raw(clip), .i_ilim_raw(ilim), .i_ac_diag_valid(dv),
      .i_ac_diag_low(dlow), .i_standby(stby), .i_parallel_bridge_mode_req(preq), .i_ch1_state(s1),
      .i_ch2_state(s2), .i_sw_freq_sel(fsel), .i_diag_req(dreq), .o_diag_start(dstart),
      .o_sw_freq_mult(mult), .o_parallel_bridge_mode(pbm),
      .o_parallel_bridge_source_sel(src), .o_highpass_corner_sel(hpc),
      .o_clip_window(cwin), .o_fault_n(fault_n), .o_warn_n(warn_n),
      .o_otsd_latched(otsd), .o_parallel_bridge_mode_fault(pbf));

   acl_i2c_host i_acl_i2c_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));

   // 100 MHz core clock
   initial
   begin
      forever #5 i_clk = ~i_clk;
   end

   // Clocks on the falling edge, where the bench moves its inputs
   task automatic w(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // Byte compare, case equality so an unknown never matches
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Single-bit compare
   task automatic chk1(input logic got, input logic exp, input string what);
      chk({7'h00, got}, {7'h00, exp}, what);
   endtask

   // Reset values, including the gap between the report byte and the controls
   task automatic t_reset();
      logic [7:0] e [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h14, 8'h00, 8'h00, 8'h40};
      i_acl_i2c_host.read_regs(8'h1E, 9);
      foreach (e[k]) chk(i_acl_i2c_host.rd_q[k], e[k], "reset value");
      chk1(fault_n, 1'b1, "fault pin idle");
      chk(cwin, 8'h14, "window port");
      $display("test reset done");
   endtask

   // Burst write across read-only flags; mask, warn and auto recovery
   task automatic t_config();
      i_acl_i2c_host.write_regs(8'h21, '{8'h68, 8'h01, 8'h02, 8'hFF, 8'hFF, 8'h47});
      chk1(src, 1'b1, "bridge source");
      chk(cwin, 8'h02, "window port");
      chk({5'h00, hpc}, 8'h07, "corner code");
      ilim = 2'b11;
      w(6);
      ilim = 2'b00;
      w(6);
      chk1(warn_n, 1'b1, "masked current limit");
      clip = 2'b11;
      w(12);
      clip = 2'b00;
      w(4);
      chk1(warn_n, 1'b0, "clip warns");
      ot = 1'b1;
      w(6);
      chk1(otsd, 1'b1, "overtemp shutdown");
      chk1(fault_n, 1'b0, "fault pin");
      ot = 1'b0;
      w(6);
      chk1(otsd, 1'b0, "auto recovery");
      $display("test config done");
   endtask

   // Switching multiples, bridge mode gating, state mismatch, diagnostics
   task automatic t_ports();
      logic [5:0] m [5] = '{acl_pkg::ACL_FSW_8, acl_pkg::ACL_FSW_10, acl_pkg::ACL_FSW_38,
         acl_pkg::ACL_FSW_44, acl_pkg::ACL_FSW_48};
      // Line-driver selection lives outside this bank; the write must still be acknowledged
      i_acl_i2c_host.write_regs(8'h00, '{8'h01});
      for (int k = 0; k < 5; k++)
      begin
         fsel = 3'(k);
         w(1);
         chk({2'h0, mult}, {2'h0, m[k]}, "switch multiple");
      end
      preq = 1'b1;
      s1 = 2'h1;
      s2 = 2'h2;
      w(5);
      chk1(pbm, 1'b0, "mode outside standby");
      stby = 1'b1;
      w(3);
      chk1(pbm, 1'b1, "mode in standby");
      chk1(fault_n, 1'b0, "mismatch fault");
      dreq = 1'b1;
      w(1);
      chk1(dstart, 1'b1, "bridged diag start");
      dreq = 1'b0;
      s2 = 2'h1;
      w(3);
      chk1(pbf, 1'b1, "mismatch sticks");
      $display("test ports done");
   endtask

   // Configure, latch, read faults, clear, then confirm nothing left
   task automatic t_clear();
      logic [7:0] e [8] = '{8'hA5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
      i_acl_i2c_host.write_regs(8'h21, '{8'h00});
      ot = 1'b1;
      w(6);
      ot = 1'b0;
      w(6);
      chk1(otsd, 1'b1, "latched overtemp");
      i_acl_i2c_host.read_regs(8'h24, 2);
      chk(i_acl_i2c_host.rd_q[0], 8'h03, "clip flags");
      chk(i_acl_i2c_host.rd_q[1], 8'h03, "limit flags");
      i_acl_i2c_host.write_regs(8'h21, '{8'h80, 8'h00});
      w(6);
      chk1(otsd, 1'b0, "overtemp cleared");
      chk1(pbf, 1'b0, "mismatch cleared");
      chk1(fault_n, 1'b1, "fault pin released");
      chk1(warn_n, 1'b1, "warn pin released");
      clip = 2'b11;
      w(12);
      clip = 2'b00;
      w(4);
      chk1(warn_n, 1'b1, "clip detect off");
      dlow = 8'hA5;
      dv = 1'b1;
      w(1);
      dv = 1'b0;
      dlow = 8'h5A;
      i_acl_i2c_host.read_regs(8'h1E, 8);
      foreach (e[k]) chk(i_acl_i2c_host.rd_q[k], e[k], "final map");
      chk(8'(i_acl_i2c_host.nack_count), 8'h00, "target acks");
      $display("test clear done");
   endtask

   // Counts, verdict and end of run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Main sequence: reset for 12 cycles, then the tests in turn
   initial
   begin
      {ot, dv, stby, preq, dreq} = 5'h00;
      {clip, ilim, s1, s2} = 8'h00;
      fsel = 3'h0;
      dlow = 8'h00;
      w(12);
      i_rstn = 1'b1;
      w(5);
      t_reset();
      t_config();
      t_ports();
      t_clear();
      end_of_test();
   end

   // Watchdog at 150k cycles, about 40 percent above the expected run of roughly 108k cycles
   initial
   begin
      #1500000;
      fail_count++;
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
